// ### pms_pkg.sv
// package: constants, types and timing for the power mode sequencer
package pms_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int  CLK_HZ        = 40_000_000;
   localparam real RESET_HOLD_MS = 1.0;
   localparam real NREQ_TO_MS    = 150.0;
   localparam real VDD_LOW_MS    = 150.0;
   localparam int  RESET_HOLD_CYC = int'($ceil(RESET_HOLD_MS * CLK_HZ / 1000.0));
   localparam int  NREQ_TO_CYC    = int'($floor(NREQ_TO_MS * CLK_HZ / 1000.0));
   localparam int  VDD_LOW_CYC    = int'($ceil(VDD_LOW_MS * CLK_HZ / 1000.0));

   // ----------------------------------------------------------------
   // mode-select encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_NORMAL = 2'h0;
   localparam logic [1:0] SEL_WD_CLR = 2'h1;
   localparam logic [1:0] SEL_STOP   = 2'h2;
   localparam logic [1:0] SEL_SLEEP  = 2'h3;

   // interrupt source bit positions
   localparam int SRC_UV   = 0;
   localparam int SRC_OV   = 1;
   localparam int SRC_TEMP = 2;
   localparam int SRC_LIN  = 3;
   localparam int SRC_HS   = 4;
   localparam int SRC_WAKE = 5;
   localparam int SRC_W    = 6;
   localparam logic [SRC_W-1:0] MASK_RST = 6'h3_F;

   typedef enum logic [2:0] {
      PMS_RESET, PMS_NREQ, PMS_NORMAL, PMS_STOP, PMS_SLEEP
   } pms_mode_e;

   // watchdog configuration pin strap
   typedef enum logic [1:0] {
      WDC_GROUND, WDC_RESISTOR, WDC_OPEN
   } pms_wdc_e;

   // raw condition inputs from analog monitors
   typedef struct packed {
      logic vdd_low;
      logic supply_uv;
      logic supply_ov;
      logic temp_warn;
      logic lin_overtemp;
      logic rx_short;
      logic hs_shutdown;
   } pms_mon_s;

   // wake sources from low-power modes
   typedef struct packed {
      logic wake_input;
      logic cyclic;
      logic forced;
      logic lin;
   } pms_wake_s;

   // one mode command written over spi
   typedef struct packed {
      logic       valid;
      logic [1:0] mode_select_bits;
   } pms_cmd_s;

   function automatic logic any_bit(input logic [SRC_W-1:0] v);
      return |v;
   endfunction

endpackage

// ### pms_sync.sv
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module pms_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         nrst,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ### pms_timer.sv
// up-counter that flags when a run condition has lasted a limit
`timescale 1ns/1ps
module pms_timer #(
   parameter int LIMIT = 4
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // control
   input  wire logic run,
   output logic      done
);
   localparam int CW = $clog2(LIMIT + 1);
   logic [CW-1:0] cnt;

   initial begin
      if (LIMIT < 1) $error("timer limit must be positive");
   end

   // counter on the internal oscillator, limit from parameter
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt  <= '0;
         done <= 1'b0;
      end else if (!run) begin
         cnt  <= '0;
         done <= 1'b0;
      end else if (cnt != CW'(LIMIT)) begin
         cnt  <= cnt + CW'(1);
         done <= (cnt == CW'(LIMIT - 1));
      end
   end
endmodule

// ### pms_sequencer.sv
// operating mode sequencer with reset and interrupt line control
`timescale 1ns/1ps
module pms_sequencer
   import pms_pkg::*;
#(
   parameter int RESET_HOLD = pms_pkg::RESET_HOLD_CYC,
   parameter int NREQ_TO    = pms_pkg::NREQ_TO_CYC,
   parameter int VDD_LOW_T  = pms_pkg::VDD_LOW_CYC
) (
   // clock and power-on reset
   input  wire logic              mclk,
   input  wire logic              nrst,
   // configuration strap and monitors
   input  wire pms_pkg::pms_wdc_e watchdog_config_pin,
   input  wire pms_pkg::pms_mon_s mon,
   input  wire pms_pkg::pms_wake_s wake,
   input  wire logic              wd_fail,
   // spi register side
   input  wire pms_pkg::pms_cmd_s mode_control_reg,
   input  wire logic              timing_control_wr,
   input  wire logic [pms_pkg::SRC_W-1:0] interrupt_mask_reg,
   input  wire logic              interrupt_source_rd,
   output logic [pms_pkg::SRC_W-1:0] interrupt_source_reg,
   output pms_pkg::pms_mode_e     mode,
   output logic                   wd_enable,
   output logic                   battery_fail_flag,
   // pins
   input  wire logic              cs_n,
   input  wire logic              rst_n_in,
   output logic                   rst_n_out,
   output logic                   rst_n_oe,
   output logic                   irq_n_out,
   output logic                   irq_n_oe,
   // regulator and lin control
   output logic                   reg_on,
   output logic                   reg_limited,
   output logic                   lin_rx_only,
   output logic                   lin_tx_enable,
   input  wire logic              lin_tx_recessive
);
   import pms_pkg::*;

   initial begin
      if (RESET_HOLD < 1 || NREQ_TO < 1 || VDD_LOW_T < 1)
         $error("timing counts must be positive");
   end

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   localparam int NS = 11 + 4 + 3;
   logic [NS-1:0] raw_in;
   logic [NS-1:0] syn;
   assign raw_in = {mon, wake, cs_n, rst_n_in, lin_tx_recessive, 4'h0};

   pms_sync #(.W(NS)) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .d    (raw_in),
      .q    (syn)
   );

   pms_mon_s  mon_s;
   pms_wake_s wake_s;
   logic      cs_s;
   logic      rstpin_s;
   logic      txr_s;
   assign mon_s    = syn[NS-1 -: 7];
   assign wake_s   = syn[NS-8 -: 4];
   assign cs_s     = syn[6];
   assign rstpin_s = syn[5];
   assign txr_s    = syn[4];

   // ----------------------------------------------------------------
   // edge detect and reset source
   // ----------------------------------------------------------------
   logic cs_d;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cs_d <= 1'b1;
      end else begin
         cs_d <= cs_s;
      end
   end

   // own release is masked until the high level has come back through the synchroniser
   logic [1:0] rst_out_d;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_out_d <= 2'h0;
      end else begin
         rst_out_d <= {rst_out_d[0], rst_n_out};
      end
   end

   logic cs_rise;
   logic ext_rst;
   logic any_wake;
   pms_mode_e state;
   assign cs_rise  = cs_s && !cs_d;
   assign ext_rst  = !rstpin_s && rst_n_out && rst_out_d[1];
   assign any_wake = |wake_s;

   // reset condition: regulator low or external pin while not driving it
   logic rst_cond;
   assign rst_cond = mon_s.vdd_low || ext_rst;

   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   logic hold_done;
   logic nreq_done;
   logic vddlow_done;

   pms_timer #(.LIMIT(RESET_HOLD)) u_hold (
      .mclk (mclk),
      .nrst (nrst),
      .run  (state == PMS_RESET && !rst_cond),
      .done (hold_done)
   );

   pms_timer #(.LIMIT(NREQ_TO)) u_nreq (
      .mclk (mclk),
      .nrst (nrst),
      .run  (state == PMS_NREQ),
      .done (nreq_done)
   );

   pms_timer #(.LIMIT(VDD_LOW_T)) u_vddlow (
      .mclk (mclk),
      .nrst (nrst),
      .run  (state == PMS_NORMAL && mon_s.vdd_low && !mon_s.supply_uv),
      .done (vddlow_done)
   );

   // ----------------------------------------------------------------
   // mode state machine
   // ----------------------------------------------------------------
   logic      timing_written;
   logic      sel_normal;
   logic      wd_clr;
   logic      stop_wake_irq;
   pms_mode_e next_state;

   assign sel_normal = mode_control_reg.valid
                       && mode_control_reg.mode_select_bits == SEL_NORMAL;
   assign wd_clr     = mode_control_reg.valid
                       && mode_control_reg.mode_select_bits == SEL_WD_CLR;

   always_comb begin
      next_state = state;
      case (state)
         PMS_RESET: begin
            if (mon_s.vdd_low && !mon_s.supply_uv && !ext_rst)
               next_state = PMS_SLEEP;
            else if (hold_done)
               next_state = (watchdog_config_pin == WDC_GROUND)
                            ? PMS_NORMAL : PMS_NREQ;
         end
         PMS_NREQ: begin
            if (rst_cond)
               next_state = PMS_RESET;
            else if (nreq_done)
               next_state = PMS_RESET;
            else if (sel_normal && timing_written)
               next_state = PMS_NORMAL;
         end
         PMS_NORMAL: begin
            if (vddlow_done)
               next_state = PMS_SLEEP;
            else if (rst_cond || (wd_enable && wd_fail))
               next_state = PMS_RESET;
            else if (mode_control_reg.valid
                     && mode_control_reg.mode_select_bits == SEL_SLEEP)
               next_state = PMS_SLEEP;
            else if (mode_control_reg.valid
                     && mode_control_reg.mode_select_bits == SEL_STOP)
               next_state = PMS_STOP;
         end
         PMS_STOP: begin
            if (mon_s.vdd_low || ext_rst)
               next_state = PMS_RESET;
            else if (any_wake || cs_rise)
               next_state = PMS_NREQ;
         end
         PMS_SLEEP: begin
            if (any_wake)
               next_state = PMS_RESET;
         end
         default: next_state = PMS_RESET;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= PMS_RESET;
      end else begin
         state <= next_state;
      end
   end

   // timing control register must be written before normal request can move to normal
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timing_written <= 1'b0;
      end else if (state != PMS_NREQ) begin
         timing_written <= 1'b0;
      end else if (timing_control_wr) begin
         timing_written <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // mode outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode        <= PMS_RESET;
         reg_on      <= 1'b1;
         reg_limited <= 1'b0;
         lin_rx_only <= 1'b1;
         wd_enable   <= 1'b0;
         rst_n_out   <= 1'b0;
         rst_n_oe    <= 1'b1;
      end else begin
         mode        <= next_state;
         reg_on      <= next_state != PMS_SLEEP;
         reg_limited <= next_state == PMS_STOP;
         lin_rx_only <= next_state != PMS_NORMAL;
         wd_enable   <= next_state == PMS_NORMAL
                        && watchdog_config_pin == WDC_RESISTOR;
         // open-drain reset: drive low only, released otherwise
         rst_n_out   <= !(next_state == PMS_RESET || next_state == PMS_SLEEP);
         rst_n_oe    <= next_state == PMS_RESET || next_state == PMS_SLEEP;
      end
   end

   // battery fail set only by power-on, cleared on source read
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         battery_fail_flag <= 1'b1;
      end else if (interrupt_source_rd) begin
         battery_fail_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // lin driver fault latch
   // ----------------------------------------------------------------
   logic lin_fault;
   logic lin_fault_now;
   assign lin_fault_now = mon_s.lin_overtemp || mon_s.rx_short || !txr_s;
   logic lin_latched;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lin_latched <= 1'b0;
      end else if (mon_s.lin_overtemp || mon_s.rx_short) begin
         lin_latched <= 1'b1;
      end else if (!lin_fault_now) begin
         lin_latched <= 1'b0;
      end
   end
   assign lin_fault = mon_s.lin_overtemp || mon_s.rx_short;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lin_tx_enable <= 1'b0;
      end else begin
         lin_tx_enable <= next_state == PMS_NORMAL && !lin_latched && !lin_fault;
      end
   end

   // ----------------------------------------------------------------
   // interrupt sources and line
   // ----------------------------------------------------------------
   logic [SRC_W-1:0] events;
   logic             irq_mode;
   assign irq_mode = (state == PMS_NORMAL || state == PMS_NREQ || state == PMS_STOP)
                     && rst_n_out;
   assign stop_wake_irq = state == PMS_STOP && next_state == PMS_NREQ
                          && any_wake;

   always_comb begin
      events           = '0;
      events[SRC_UV]   = mon_s.supply_uv;
      events[SRC_OV]   = mon_s.supply_ov;
      events[SRC_TEMP] = mon_s.temp_warn;
      events[SRC_LIN]  = lin_fault;
      events[SRC_HS]   = mon_s.hs_shutdown;
      events[SRC_WAKE] = stop_wake_irq;
      if (state == PMS_STOP)
         events[SRC_WAKE-1:0] = '0;
      events = events & interrupt_mask_reg;
   end

   // sticky sources; a new event wins over the read that clears
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         interrupt_source_reg <= '0;
      end else begin
         interrupt_source_reg <= (interrupt_source_rd ? '0 : interrupt_source_reg)
                                 | (irq_mode ? events : '0);
      end
   end

   // wake pending blocks other sources from raising the line
   logic wake_pending;
   assign wake_pending = interrupt_source_reg[SRC_WAKE];

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_n_out <= 1'b1;
         irq_n_oe  <= 1'b0;
      end else if (!irq_mode) begin
         irq_n_out <= 1'b1;
         irq_n_oe  <= 1'b0;
      end else if (events[SRC_WAKE]) begin
         // a one-cycle wake event must not be lost to a read in the same cycle
         irq_n_out <= 1'b0;
         irq_n_oe  <= 1'b1;
      end else if (interrupt_source_rd) begin
         irq_n_out <= 1'b1;
         irq_n_oe  <= 1'b0;
      end else if (!wake_pending && any_bit(events)) begin
         irq_n_out <= 1'b0;
         irq_n_oe  <= 1'b1;
      end
   end

   logic unused;
   assign unused = wd_clr ^ (|syn[3:0]) ^ (|MASK_RST);
endmodule

// ### pms_sequencer_checker.sv
// port assertions for the power mode sequencer
`timescale 1ns/1ps
module pms_sequencer_checker
   import pms_pkg::*;
#(
   parameter int RESET_HOLD = 20,
   parameter int NREQ_TO    = 200
) (
   // clock and reset
   input wire logic               mclk,
   input wire logic               nrst,
   // inputs
   input wire pms_pkg::pms_wdc_e  watchdog_config_pin,
   input wire pms_pkg::pms_cmd_s  mode_control_reg,
   input wire logic               interrupt_source_rd,
   // outputs
   input wire pms_pkg::pms_mode_e mode,
   input wire logic               wd_enable,
   input wire logic               rst_n_oe,
   input wire logic               irq_n_oe,
   input wire logic               reg_on,
   input wire logic               reg_limited,
   input wire logic               lin_rx_only,
   input wire logic               lin_tx_enable
);
   int hold_cnt;
   int nreq_cnt;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // cycles the reset line has been driven, cycles spent in normal request
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hold_cnt <= 0;
         nreq_cnt <= 0;
      end else begin
         hold_cnt <= rst_n_oe ? ((hold_cnt < 99999) ? hold_cnt + 1 : hold_cnt) : 0;
         nreq_cnt <= (mode == PMS_NREQ) ? nreq_cnt + 1 : 0;
      end
   end
   a_reset_hold_time: assert property ($fell(rst_n_oe) |-> hold_cnt >= RESET_HOLD)
      else $error("reset line released too early");
   a_nreq_timeout: assert property (nreq_cnt <= NREQ_TO + 8)
      else $error("normal request outlived its timeout");
   a_nreq_lines: assert property (mode == PMS_NREQ |->
      reg_on && lin_rx_only && !rst_n_oe)
      else $error("normal request outputs wrong");
   a_sleep_quiet: assert property (mode == PMS_SLEEP |-> !reg_on && !irq_n_oe)
      else $error("sleep with regulator or irq active");
   a_stop_regulator: assert property (mode == PMS_STOP |-> reg_on && reg_limited)
      else $error("stop regulator not limited");
   a_stop_entry: assert property ($rose(mode == PMS_STOP) |->
      $past(mode) == PMS_NORMAL
      && ($past(mode_control_reg.valid) || $past(mode_control_reg.valid, 2)))
      else $error("stop entered without command");
   a_irq_rise_mode: assert property ($rose(irq_n_oe) |->
      !rst_n_oe && mode inside {PMS_NREQ, PMS_NORMAL, PMS_STOP})
      else $error("irq raised in wrong mode");
   a_irq_ack_release: assert property (interrupt_source_rd && irq_n_oe |->
      ##[1:2] !irq_n_oe)
      else $error("irq not released after read");
   a_irq_stays_low: assert property (irq_n_oe && !interrupt_source_rd
      && mode != PMS_RESET && mode != PMS_SLEEP |=> irq_n_oe || mode != $past(mode))
      else $error("irq released without read");
   a_wd_enable_mode: assert property (wd_enable |->
      watchdog_config_pin == WDC_RESISTOR && (mode == PMS_NORMAL || $past(mode) == PMS_NORMAL))
      else $error("watchdog enabled outside normal");
   a_lin_tx_normal: assert property (lin_tx_enable |->
      mode == PMS_NORMAL || $past(mode) == PMS_NORMAL)
      else $error("lin transmit outside normal");
   a_ground_skip: assert property (watchdog_config_pin == WDC_GROUND |->
      mode != PMS_NREQ)
      else $error("normal request with grounded strap");
endmodule

// ### pms_host_model.sv
// host microcontroller model: boot commands and interrupt acknowledge
`timescale 1ns/1ps
module pms_host_model
   import pms_pkg::*;
#(
   parameter int ACK_WAIT = 12
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               nrst,
   // device status and bench control
   input  wire pms_pkg::pms_mode_e mode,
   input  wire logic               irq_n_oe,
   input  wire logic               auto_en,
   input  wire pms_pkg::pms_cmd_s  host_cmd,
   // register accesses
   output pms_pkg::pms_cmd_s       mode_control_reg,
   output logic                    timing_control_wr,
   output logic                    interrupt_source_rd
);
   pms_cmd_s boot_cmd = '0;
   assign mode_control_reg = host_cmd.valid ? host_cmd : boot_cmd;
   initial timing_control_wr = 1'h0;
   initial interrupt_source_rd = 1'h0;
   // timing write then normal command, well inside the timeout
   initial forever begin
      @(posedge mclk);
      if (nrst && auto_en && mode == PMS_NREQ) begin
         repeat (4) @(posedge mclk);
         #1 timing_control_wr = 1'h1;
         @(posedge mclk);
         #1 timing_control_wr = 1'h0;
         repeat (2) @(posedge mclk);
         #1 boot_cmd = '{valid: 1'h1, mode_select_bits: SEL_NORMAL};
         @(posedge mclk);
         #1 boot_cmd = '0;
         repeat (4) @(posedge mclk);
      end
   end
   // slow acknowledge by a source register read
   initial forever begin
      @(posedge mclk);
      if (nrst && irq_n_oe === 1'h1) begin
         repeat (ACK_WAIT) @(posedge mclk);
         #1 interrupt_source_rd = 1'h1;
         @(posedge mclk);
         #1 interrupt_source_rd = 1'h0;
         repeat (3) @(posedge mclk);
      end
   end
endmodule

// ### power_mode_sequencer_bench.sv
// self-checking bench for the power mode sequencer
`timescale 1ns/1ps
module power_mode_sequencer_bench;
   import pms_pkg::*;
   localparam int RH = 20;
   localparam int NT = 200;
   logic             mclk      = 1'h0;
   logic             nrst      = 1'h0;
   pms_wdc_e         strap     = WDC_RESISTOR;
   pms_mon_s         mon       = '0;
   pms_wake_s        wake      = '0;
   logic             wd_fail   = 1'h0;
   logic             cs_n      = 1'h1;
   logic             ext_rst_n = 1'h1;
   logic             tx_rec    = 1'h1;
   logic [SRC_W-1:0] mask      = MASK_RST;
   pms_cmd_s         host_cmd  = '0;
   logic             auto_en   = 1'h1;
   pms_cmd_s         mode_control_reg;
   logic             timing_control_wr, interrupt_source_rd, rst_pin;
   logic [SRC_W-1:0] interrupt_source_reg;
   pms_mode_e        mode;
   logic             wd_enable, battery_fail_flag, rst_n_out, rst_n_oe, irq_n_oe, irq_n_out;
   logic             reg_on, reg_limited, lin_rx_only, lin_tx_enable;
   int               err_total = 0;
   int               samples_checked = 0;
   always #12.5 mclk = ~mclk;
   // open-drain reset pin: device pull-down and external reset wired together
   assign rst_pin = (rst_n_oe ? rst_n_out : 1'h1) & ext_rst_n;
   pms_sequencer #(.RESET_HOLD(RH), .NREQ_TO(NT), .VDD_LOW_T(NT)) i_dut (
      .mclk(mclk), .nrst(nrst), .watchdog_config_pin(strap), .mon(mon), .wake(wake),
      .wd_fail(wd_fail), .mode_control_reg(mode_control_reg),
      .timing_control_wr(timing_control_wr), .interrupt_mask_reg(mask),
      .interrupt_source_rd(interrupt_source_rd), .interrupt_source_reg(interrupt_source_reg),
      .mode(mode), .wd_enable(wd_enable), .battery_fail_flag(battery_fail_flag),
      .cs_n(cs_n), .rst_n_in(rst_pin), .rst_n_out(rst_n_out), .rst_n_oe(rst_n_oe),
      .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .reg_on(reg_on), .reg_limited(reg_limited),
      .lin_rx_only(lin_rx_only), .lin_tx_enable(lin_tx_enable), .lin_tx_recessive(tx_rec));
   pms_host_model i_host (
      .mclk(mclk), .nrst(nrst), .mode(mode), .irq_n_oe(irq_n_oe), .auto_en(auto_en),
      .host_cmd(host_cmd), .mode_control_reg(mode_control_reg),
      .timing_control_wr(timing_control_wr), .interrupt_source_rd(interrupt_source_rd));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wait_mode(input pms_mode_e m, input int n);
      int i;
      i = 0;
      while (mode !== m && i < n) begin
         step(1);
         i++;
      end
      check("mode", m, mode);
   endtask
   task automatic send(input logic [1:0] sel);
      host_cmd = '{valid: 1'h1, mode_select_bits: sel};
      step(1);
      host_cmd = '0;
   endtask
   task automatic wait_ack();
      int i;
      i = 0;
      while (irq_n_oe === 1'h1 && i < 40) begin
         step(1);
         i++;
      end
      check("irq released", 1'h0, irq_n_oe);
      check("irq line high", 1'h1, irq_n_out);
   endtask
   task automatic t_power_up();
      int n;
      n = 0;
      check("battery fail set", 1'h1, battery_fail_flag);
      while (rst_n_oe === 1'h1 && n < 200) begin
         step(1);
         n++;
      end
      check("reset stretch", 1'h1, n >= RH);
      check("mode after reset", PMS_NREQ, mode);
      check("request regulator", 1'h1, reg_on & lin_rx_only);
      wait_mode(PMS_NORMAL, 40);
      check("watchdog on", 1'h1, wd_enable);
      send(SEL_WD_CLR);
      step(2);
      check("watchdog clear", PMS_NORMAL, mode);
      $display("power up done");
   endtask
   task automatic t_nreq();
      auto_en = 1'h0;
      wd_fail = 1'h1;
      step(1);
      wd_fail = 1'h0;
      wait_mode(PMS_RESET, 8);
      wait_mode(PMS_NREQ, RH + 20);
      send(SEL_NORMAL);
      step(4);
      check("normal refused", PMS_NREQ, mode);
      wait_mode(PMS_RESET, NT + 10);
      auto_en = 1'h1;
      wait_mode(PMS_NORMAL, RH + 60);
      $display("normal request done");
   endtask
   task automatic t_stop_wake(input int kind);
      send(SEL_STOP);
      wait_mode(PMS_STOP, 8);
      case (kind)
         0: wake.wake_input = 1'h1;
         1: cs_n = 1'h0;
         default: ext_rst_n = 1'h0;
      endcase
      step(4);
      wake.wake_input = 1'h0;
      cs_n = 1'h1;
      if (kind == 2) begin
         wait_mode(PMS_RESET, 10);
         ext_rst_n = 1'h1;
      end
      wait_mode(PMS_NREQ, RH + 20);
      step(1);
      check("stop wake irq", kind == 0, irq_n_oe);
      if (kind == 0) begin
         check("wake source", 1'h1, interrupt_source_reg[SRC_WAKE]);
         wait_ack();
         check("wake source cleared", 1'h0, interrupt_source_reg[SRC_WAKE]);
      end
      wait_mode(PMS_NORMAL, 60);
      $display("stop wake %0d done", kind);
   endtask
   task automatic t_faults();
      int mb [4] = '{5, 4, 3, 0};
      int sb [4] = '{SRC_UV, SRC_OV, SRC_TEMP, SRC_HS};
      for (int i = 0; i < 4; i++) begin
         mon[mb[i]] = 1'h1;
         step(6);
         check("fault irq", 1'h1, irq_n_oe);
         check("irq line low", 1'h0, irq_n_out);
         check("fault source", 1'h1, interrupt_source_reg[sb[i]]);
         mon[mb[i]] = 1'h0;
         wait_ack();
      end
      mask[SRC_OV] = 1'h0;
      mon.supply_ov = 1'h1;
      step(8);
      check("masked fault", 1'h0, irq_n_oe);
      mon.supply_ov = 1'h0;
      mask = MASK_RST;
      $display("faults done");
   endtask
   task automatic t_lin_fault();
      tx_rec = 1'h0;
      mon.lin_overtemp = 1'h1;
      step(6);
      check("lin off", 1'h0, lin_tx_enable);
      mon.lin_overtemp = 1'h0;
      step(4);
      check("lin waits recessive", 1'h0, lin_tx_enable);
      tx_rec = 1'h1;
      step(6);
      check("lin restarted", 1'h1, lin_tx_enable);
      wait_ack();
      $display("lin fault done");
   endtask
   task automatic t_sleep();
      send(SEL_SLEEP);
      wait_mode(PMS_SLEEP, 8);
      check("sleep regulator", 1'h0, reg_on);
      mon.supply_ov = 1'h1;
      step(8);
      check("sleep irq", 1'h0, irq_n_oe);
      mon.supply_ov = 1'h0;
      wake.lin = 1'h1;
      wait_mode(PMS_RESET, 10);
      wake.lin = 1'h0;
      check("sleep wake reset", 1'h1, rst_n_oe);
      wait_mode(PMS_NREQ, RH + 20);
      check("battery fail", 1'h0, battery_fail_flag);
      wait_mode(PMS_NORMAL, 60);
      mon.vdd_low = 1'h1;
      wait_mode(PMS_RESET, 8);
      wait_mode(PMS_SLEEP, 8);
      mon.vdd_low = 1'h0;
      wake.forced = 1'h1;
      wait_mode(PMS_RESET, 10);
      wake.forced = 1'h0;
      wait_mode(PMS_NORMAL, RH + 60);
      $display("sleep done");
   endtask
   task automatic t_ground();
      nrst = 1'h0;
      strap = WDC_GROUND;
      step(2);
      nrst = 1'h1;
      wait_mode(PMS_NORMAL, RH + 20);
      check("watchdog off", 1'h0, wd_enable);
      nrst = 1'h0;
      strap = WDC_RESISTOR;
      step(2);
      nrst = 1'h1;
      wait_mode(PMS_NORMAL, RH + 60);
      $display("ground strap done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      step(4);
      nrst = 1'h1;
      t_power_up();
      t_nreq();
      for (int k = 0; k < 3; k++) t_stop_wake(k);
      t_faults();
      t_lin_fault();
      t_sleep();
      t_ground();
      tally_and_finish();
   end
endmodule
bind pms_sequencer pms_sequencer_checker #(.RESET_HOLD(RESET_HOLD), .NREQ_TO(NREQ_TO)) i_chk (
   .mclk(mclk), .nrst(nrst), .watchdog_config_pin(watchdog_config_pin),
   .mode_control_reg(mode_control_reg), .interrupt_source_rd(interrupt_source_rd),
   .mode(mode), .wd_enable(wd_enable), .rst_n_oe(rst_n_oe), .irq_n_oe(irq_n_oe),
   .reg_on(reg_on), .reg_limited(reg_limited), .lin_rx_only(lin_rx_only),
   .lin_tx_enable(lin_tx_enable));
